//--- rtl/atacb_consts.svh
// constants of the vendor ATA command block executor
// assumes inclusion by bare name from the rtl folder
`ifndef ATACB_CONSTS_SVH
`define ATACB_CONSTS_SVH

`define ATACB_BLOCK_LEN 5'h10
`define ATACB_LAST_BYTE 4'hF
`define ATACB_SUBCMD 8'h24
`define ATACB_OFS_SIG 4'h0
`define ATACB_OFS_SUB 4'h1
`define ATACB_OFS_ACT 4'h2
`define ATACB_OFS_MASK 4'h3
`define ATACB_OFS_BCNT 4'h4
`define ATACB_OFS_WDATA 4'h5
`define ATACB_OFS_DEVREG 4'hB
`define ATACB_BIT_DEVSRC 5
`define ATACB_BIT_DERR 4
`define ATACB_BIT_PERR 3
`define ATACB_BIT_NOPOLL 2
`define ATACB_BIT_LATESEL 1
`define ATACB_BIT_READBACK 0
`define ATACB_BIT_DEV 4
`define ATACB_BIT_BSY 7
`define ATACB_IDX_CTL 3'h0
`define ATACB_IDX_DEV 3'h6
`define ATACB_IDX_CMD 3'h7
`define ATACB_ADDR_ALT 3'h6
`define ATACB_ADDR_DATA 3'h0
`define ATACB_STEPS 4'h8
`define ATACB_SECT_256 9'h100
`define ATACB_FIFO_W 8
`define ATACB_FIFO_D 16

`endif

//--- rtl/atacb_exec.sv
// vendor ATA command block executor: parses a 16-byte block and
// runs it on a task-file register port, returning data via a fifo
// assumes one clock, synchronous inputs, one task-file access at a time
//
// Summary of operation
// - act only on matching signature and subcommand
// - drive bit from startup unit or byte 0x0B
// - halt data on drive error unless ignored
// - halt data on phase error unless ignored
// - poll alternate status until not busy
// - drive select before or after register writes
// - read-back reads chosen registers, index 7 read as status
// - read-back bytes ordered alt status to status
// - chosen registers accessed in ascending order, drive select excepted
// - read-back always eight bytes, zeros unchosen
// - block count power of two, zero means 256
// - bytes 5 to 12 carry register write data
// - write bytes map control through command register
`timescale 1ns/1ps
`default_nettype none
`include "atacb_consts.svh"
module atacb_exec (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire atacb_pkg::atacb_byte_t i_signature,
  input wire logic i_lun_dev,
  input wire logic i_cmd_valid,
  input wire atacb_pkg::atacb_byte_t i_cmd_byte,
  output logic o_cmd_ready,
  input wire logic [15:0] i_xfer_len,
  output logic o_tf_req,
  output logic o_tf_write,
  output logic o_tf_ctl,
  output logic [2:0] o_tf_addr,
  output atacb_pkg::atacb_byte_t o_tf_wdata,
  input wire logic i_tf_ack,
  input wire atacb_pkg::atacb_byte_t i_tf_rdata,
  input wire logic i_drive_error,
  input wire logic i_phase_error,
  output logic o_rd_valid,
  output atacb_pkg::atacb_byte_t o_rd_data,
  input wire logic i_rd_ready,
  output logic [8:0] o_block_sectors,
  output logic o_busy,
  output logic o_done,
  output logic o_failed,
  output logic o_not_vendor
);
  import atacb_pkg::*;

  atacb_state_t st_r, st_nxt;           // sequencer state
  atacb_byte_t cb_r [16];               // received command block
  atacb_byte_t cb_nxt [16];
  logic [3:0] cnt_r, cnt_nxt;           // receive byte count
  logic [3:0] step_r, step_nxt;         // register access step
  logic [15:0] len_r, len_nxt;          // data bytes left
  logic req_nxt, wr_nxt, ctl_nxt;       // task-file port next values
  logic [2:0] addr_nxt;
  atacb_byte_t wdata_nxt;
  logic [8:0] sect_nxt;
  logic done_nxt, fail_nxt, nv_nxt;
  logic push;                           // fifo write strobe
  atacb_byte_t push_data;
  logic fifo_ready;
  logic [2:0] idx;                      // register index of this step
  logic vendor, bcnt_ok, acc_ok, halt;
  atacb_byte_t act, mask, bcnt;

  // action fields
  assign act = cb_r[`ATACB_OFS_ACT];
  assign mask = cb_r[`ATACB_OFS_MASK];
  assign bcnt = cb_r[`ATACB_OFS_BCNT];
  assign vendor = (cb_r[`ATACB_OFS_SIG] == i_signature) &&
                  (cb_r[`ATACB_OFS_SUB] == `ATACB_SUBCMD);
  assign bcnt_ok = ((bcnt & (bcnt - 8'h01)) == 8'h00);
  assign acc_ok = o_tf_req && i_tf_ack;
  // error halt unless the matching ignore flag is set
  assign halt = (i_drive_error && !act[`ATACB_BIT_DERR]) ||
                (i_phase_error && !act[`ATACB_BIT_PERR]);

  // step to register index; device select early or late
  always_comb begin
    idx = step_r[2:0];
    if (st_r == ST_WR) begin
      if (!act[`ATACB_BIT_LATESEL]) begin
        if (step_r == 4'h0) idx = `ATACB_IDX_DEV;
        else if (step_r < 4'h7) idx = 3'(step_r - 4'h1);
      end else if (step_r == 4'h6) begin
        idx = `ATACB_IDX_CMD;
      end else if (step_r == 4'h7) begin
        idx = `ATACB_IDX_DEV;
      end
    end
  end

  // main sequencer next state
  always_comb begin
    st_nxt = st_r;
    cb_nxt = cb_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    len_nxt = len_r;
    req_nxt = o_tf_req;
    wr_nxt = o_tf_write;
    ctl_nxt = o_tf_ctl;
    addr_nxt = o_tf_addr;
    wdata_nxt = o_tf_wdata;
    sect_nxt = o_block_sectors;
    done_nxt = 1'b0;
    fail_nxt = 1'b0;
    nv_nxt = 1'b0;
    push = 1'b0;
    push_data = 8'h00;
    case (st_r)
      // gather sixteen bytes
      ST_IDLE, ST_RECV: begin
        if (i_cmd_valid && o_cmd_ready) begin
          cb_nxt[cnt_r] = i_cmd_byte;
          cnt_nxt = cnt_r + 4'h1;
          st_nxt = (cnt_r == `ATACB_LAST_BYTE) ? ST_CHECK : ST_RECV;
        end
      end
      // decode block
      ST_CHECK: begin
        step_nxt = 4'h0;
        len_nxt = i_xfer_len;
        if (!vendor) begin
          nv_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end else if (!bcnt_ok) begin
          done_nxt = 1'b1;
          fail_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end else begin
          sect_nxt = (bcnt == 8'h00) ? `ATACB_SECT_256 : {1'b0, bcnt};
          if (act[`ATACB_BIT_NOPOLL]) begin
            st_nxt = act[`ATACB_BIT_READBACK] ? ST_RD : ST_WR;
          end else begin
            st_nxt = ST_POLL;
          end
        end
      end
      // read alternate status until busy clears
      ST_POLL: begin
        if (!o_tf_req) begin
          req_nxt = 1'b1;
          wr_nxt = 1'b0;
          ctl_nxt = 1'b1;
          addr_nxt = `ATACB_ADDR_ALT;
        end else if (acc_ok) begin
          req_nxt = 1'b0;
          if (!i_tf_rdata[`ATACB_BIT_BSY]) begin
            st_nxt = act[`ATACB_BIT_READBACK] ? ST_RD : ST_WR;
          end
        end
      end
      // write chosen registers from bytes 5 to 12
      ST_WR: begin
        if (step_r == `ATACB_STEPS) begin
          st_nxt = (len_r != 16'h0000) ? ST_DATA : ST_DONE;
        end else if (!mask[idx]) begin
          step_nxt = step_r + 4'h1;
        end else if (!o_tf_req) begin
          req_nxt = 1'b1;
          wr_nxt = 1'b1;
          ctl_nxt = (idx == `ATACB_IDX_CTL);
          addr_nxt = (idx == `ATACB_IDX_CTL) ? `ATACB_ADDR_ALT : idx;
          wdata_nxt = cb_r[`ATACB_OFS_WDATA + 4'(idx)];
          if (idx == `ATACB_IDX_DEV && !act[`ATACB_BIT_DEVSRC]) begin
            wdata_nxt[`ATACB_BIT_DEV] = i_lun_dev;
          end
        end else if (acc_ok) begin
          req_nxt = 1'b0;
          step_nxt = step_r + 4'h1;
        end
      end
      // read-back of eight bytes, zero for unchosen
      ST_RD: begin
        if (step_r == `ATACB_STEPS) begin
          st_nxt = ST_DONE;
        end else if (!mask[idx]) begin
          if (fifo_ready) begin
            push = 1'b1;
            step_nxt = step_r + 4'h1;
          end
        end else if (!o_tf_req) begin
          if (fifo_ready) begin
            req_nxt = 1'b1;
            wr_nxt = 1'b0;
            ctl_nxt = (idx == `ATACB_IDX_CTL);
            addr_nxt = (idx == `ATACB_IDX_CTL) ? `ATACB_ADDR_ALT : idx;
          end
        end else if (acc_ok) begin
          req_nxt = 1'b0;
          push = 1'b1;
          push_data = i_tf_rdata;
          step_nxt = step_r + 4'h1;
        end
      end
      // data-in phase, one byte per data register read
      ST_DATA: begin
        if (!o_tf_req) begin
          if (fifo_ready) begin
            req_nxt = 1'b1;
            wr_nxt = 1'b0;
            ctl_nxt = 1'b0;
            addr_nxt = `ATACB_ADDR_DATA;
          end
        end else if (acc_ok) begin
          req_nxt = 1'b0;
          push = 1'b1;
          push_data = i_tf_rdata;
          len_nxt = len_r - 16'h0001;
          if (halt) begin
            done_nxt = 1'b1;
            fail_nxt = 1'b1;
            st_nxt = ST_IDLE;
          end else if (len_r == 16'h0001) begin
            st_nxt = ST_DONE;
          end
        end
      end
      // good completion
      ST_DONE: begin
        done_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (st_nxt == ST_IDLE && st_r != ST_IDLE && st_r != ST_RECV) begin
      cnt_nxt = 4'h0;
    end
  end

  // register everything
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r <= ST_IDLE;
      for (int i = 0; i < 16; i++) cb_r[i] <= 8'h00;
      cnt_r <= 4'h0;
      step_r <= 4'h0;
      len_r <= 16'h0000;
      o_tf_req <= 1'b0;
      o_tf_write <= 1'b0;
      o_tf_ctl <= 1'b0;
      o_tf_addr <= 3'h0;
      o_tf_wdata <= 8'h00;
      o_block_sectors <= `ATACB_SECT_256;
      o_done <= 1'b0;
      o_failed <= 1'b0;
      o_not_vendor <= 1'b0;
      o_busy <= 1'b0;
      o_cmd_ready <= 1'b0;
    end else if (i_ce) begin
      st_r <= st_nxt;
      cb_r <= cb_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      len_r <= len_nxt;
      o_tf_req <= req_nxt;
      o_tf_write <= wr_nxt;
      o_tf_ctl <= ctl_nxt;
      o_tf_addr <= addr_nxt;
      o_tf_wdata <= wdata_nxt;
      o_block_sectors <= sect_nxt;
      o_done <= done_nxt;
      o_failed <= fail_nxt;
      o_not_vendor <= nv_nxt;
      o_busy <= (st_nxt != ST_IDLE);
      o_cmd_ready <= (st_nxt == ST_IDLE || st_nxt == ST_RECV);
    end
  end

  // return data buffer
  atacb_fifo #(.W(`ATACB_FIFO_W), .D(`ATACB_FIFO_D)) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_in_valid(push),
    .i_in_data(push_data),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_rd_valid),
    .o_out_data(o_rd_data),
    .i_out_ready(i_rd_ready)
  );

  a_sig_mismatch: assert property (@(posedge i_clk)
    disable iff (i_reset || !i_ce)
    (st_r == ST_CHECK && !vendor) |=> (o_not_vendor && !o_done))
    else $error("foreign block not passed on");
  a_bad_count: assert property (@(posedge i_clk)
    disable iff (i_reset || !i_ce)
    (st_r == ST_CHECK && vendor && !bcnt_ok) |=> (o_done && o_failed))
    else $error("illegal block count not failed");
  a_dev_source: assert property (@(posedge i_clk)
    disable iff (i_reset || !i_ce)
    (o_tf_req && o_tf_write && !o_tf_ctl && o_tf_addr == `ATACB_IDX_DEV)
    |-> (o_tf_wdata[`ATACB_BIT_DEV] == (act[`ATACB_BIT_DEVSRC] ?
         cb_r[`ATACB_OFS_DEVREG][`ATACB_BIT_DEV] : i_lun_dev)))
    else $error("drive bit from wrong source");
  a_readback_nowr: assert property (@(posedge i_clk)
    disable iff (i_reset || !i_ce)
    (st_r == ST_RD) |-> !(o_tf_req && o_tf_write))
    else $error("write during read-back");
  a_poll_busy: assert property (@(posedge i_clk)
    disable iff (i_reset || !i_ce)
    (st_r == ST_POLL && acc_ok && i_tf_rdata[`ATACB_BIT_BSY])
    |=> (st_r == ST_POLL))
    else $error("left poll while busy");
  a_early_select: assert property (@(posedge i_clk)
    disable iff (i_reset || !i_ce)
    (st_r == ST_WR && step_r == 4'h0 && o_tf_req &&
     !act[`ATACB_BIT_LATESEL]) |-> (o_tf_addr == `ATACB_IDX_DEV && !o_tf_ctl))
    else $error("drive select not first");
  a_halt_error: assert property (@(posedge i_clk)
    disable iff (i_reset || !i_ce)
    (st_r == ST_DATA && acc_ok && i_drive_error &&
     !act[`ATACB_BIT_DERR]) |=> (o_done && o_failed ##1 st_r == ST_IDLE))
    else $error("drive error did not halt");
  a_zero_fill: assert property (@(posedge i_clk)
    disable iff (i_reset || !i_ce)
    (st_r == ST_RD && push && !mask[idx]) |-> (push_data == 8'h00))
    else $error("unchosen read-back byte not zero");
  a_sect_decode: assert property (@(posedge i_clk)
    disable iff (i_reset || !i_ce)
    (st_r == ST_CHECK && vendor && bcnt == 8'h00) |=>
    (o_block_sectors == `ATACB_SECT_256))
    else $error("zero count not 256 sectors");
endmodule
`default_nettype wire

//--- rtl/atacb_fifo.sv
// shift-register fifo; the head entry is the output register
// assumes one clock, synchronous reset, clock enable freezes all
`timescale 1ns/1ps
`default_nettype none
module atacb_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] q_r [D];       // entries, 0 is head
  logic [W-1:0] q_nxt [D];
  logic [CW-1:0] cnt_r;        // fill level
  logic [CW-1:0] cnt_nxt;
  logic push;
  logic pop;

  // handshakes
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = q_r[0];

  // per entry: shift on pop, write at the tail on push
  genvar g;
  for (g = 0; g < D; g++) begin : g_ent
    always_comb begin
      q_nxt[g] = q_r[g];
      if (pop) begin
        q_nxt[g] = (g < D - 1) ? q_r[(g < D - 1) ? g + 1 : g] : q_r[g];
      end
      if (push && (CW'(g) == (pop ? cnt_r - CW'(1) : cnt_r))) begin
        q_nxt[g] = i_in_data;
      end
    end
    always_ff @(posedge i_clk) begin
      if (i_ce) begin
        q_r[g] <= q_nxt[g];
      end
    end
  end

  // level and flags
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) cnt_nxt = cnt_r + CW'(1);
    else if (pop && !push) cnt_nxt = cnt_r - CW'(1);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_r <= '0;
      o_out_valid <= 1'b0;
      o_in_ready <= 1'b0;
    end else if (i_ce) begin
      cnt_r <= cnt_nxt;
      o_out_valid <= (cnt_nxt != '0);
      o_in_ready <= (cnt_nxt != CW'(D));
    end
  end
endmodule
`default_nettype wire

//--- rtl/atacb_pkg.sv
// types shared by the command block executor files
// assumes nothing of its surroundings
package atacb_pkg;
  typedef logic [7:0] atacb_byte_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_CHECK, ST_POLL, ST_WR, ST_RD, ST_DATA, ST_DONE
  } atacb_state_t;
endpackage

//--- verification/atacb_drive_model.sv
// drive-side model: answers task-file register accesses
// assumes one access at a time, request held until the ack edge
`timescale 1ns/1ps
`default_nettype none
module atacb_drive_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_tf_req,
  input wire logic i_tf_write,
  input wire logic i_tf_ctl,
  input wire logic [2:0] i_tf_addr,
  input wire logic [7:0] i_tf_wdata,
  input wire logic i_slow,
  input wire logic [3:0] i_busy_reads,
  output logic o_tf_ack,
  output logic [7:0] o_tf_rdata
);
  logic [7:0] regs [0:7]; // command block registers
  logic [12:0] log_a [0:255]; // write, ctl, addr, data per access
  int lcount; // accesses answered
  int dcount; // data bytes handed out
  int wait_cnt; // cycles spent on a slow access
  int busy_left; // busy status reads still due
  logic [3:0] busy_set; // last busy figure loaded
  logic [7:0] val; // value of this access
  // answer each request once, at once or after three cycles
  always_ff @(posedge i_clk) begin
    o_tf_ack <= 1'b0;
    o_tf_rdata <= ~o_tf_rdata; // released bus keeps no stale value
    if (i_reset) begin
      lcount <= 0;
      dcount <= 0;
      wait_cnt <= 0;
      busy_left <= 0;
      busy_set <= 4'h0;
      for (int k = 0; k < 8; k++) regs[k] <= 8'hA0 + k[7:0];
    end else if (i_busy_reads != busy_set) begin
      busy_set <= i_busy_reads;
      busy_left <= int'(i_busy_reads);
    end else if (i_tf_req && !o_tf_ack) begin
      if (i_slow && wait_cnt < 3) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        o_tf_ack <= 1'b1;
        if (i_tf_write) begin
          val = i_tf_wdata;
          if (!i_tf_ctl) regs[i_tf_addr] <= i_tf_wdata;
        end else if (i_tf_ctl) begin
          val = (busy_left > 0) ? 8'h80 : 8'h50;
          if (busy_left > 0) busy_left <= busy_left - 1;
        end else if (i_tf_addr == 3'h0) begin
          val = dcount[7:0] ^ 8'h5A; // data pattern
          dcount <= dcount + 1;
        end else begin
          val = regs[i_tf_addr];
        end
        if (!i_tf_write) o_tf_rdata <= val;
        log_a[lcount[7:0]] <= {i_tf_write, i_tf_ctl, i_tf_addr, val};
        lcount <= lcount + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/atacb_exec_tb_top.sv
// testbench for the vendor command block executor
// assumes the drive model file and a 50 ns clock
`timescale 1ns/1ps
`default_nettype none
module atacb_exec_tb_top;
  import atacb_pkg::*;
  localparam atacb_byte_t SIG = 8'h5C; // arbitrary signature value
  typedef struct packed {
    logic [7:0] cnt;
    logic [8:0] sect;
    logic fail;
  } atacb_row_t;
  logic i_clk, i_reset, i_lun_dev, i_cmd_valid, i_tf_ack, i_rd_ready;
  logic i_drive_error, i_phase_error, slow, f, nv, ce;
  logic o_cmd_ready, o_tf_req, o_tf_write, o_tf_ctl, o_rd_valid;
  logic o_busy, o_done, o_failed, o_not_vendor;
  logic [2:0] o_tf_addr;
  logic [3:0] busy_n;
  logic [8:0] o_block_sectors;
  logic [15:0] i_xfer_len;
  atacb_byte_t i_cmd_byte, i_tf_rdata, o_tf_wdata, o_rd_data, e;
  atacb_byte_t blk [16]; // command block under test
  atacb_byte_t wd [8]; // register write bytes
  atacb_byte_t rx_q [$]; // bytes leaving the fifo
  int bad_count, n_tests, l0, d0, k0, r;
  // block count table: code, sectors, refused
  atacb_row_t rows [12] = '{'{8'h00, 9'h100, 0}, '{8'h01, 9'h001, 0},
    '{8'h02, 9'h002, 0}, '{8'h04, 9'h004, 0}, '{8'h08, 9'h008, 0},
    '{8'h10, 9'h010, 0}, '{8'h20, 9'h020, 0}, '{8'h40, 9'h040, 0},
    '{8'h80, 9'h080, 0}, '{8'h03, 9'h000, 1}, '{8'hFF, 9'h000, 1},
    '{8'h81, 9'h000, 1}};
  // error cases: failed, drive error, phase error, action byte
  logic [10:0] errs [4] = '{11'h604, 11'h214, 11'h504, 11'h10C};

  atacb_exec dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
    .i_signature(SIG), .i_lun_dev(i_lun_dev), .i_cmd_valid(i_cmd_valid),
    .i_cmd_byte(i_cmd_byte), .o_cmd_ready(o_cmd_ready),
    .i_xfer_len(i_xfer_len), .o_tf_req(o_tf_req), .o_tf_write(o_tf_write),
    .o_tf_ctl(o_tf_ctl), .o_tf_addr(o_tf_addr), .o_tf_wdata(o_tf_wdata),
    .i_tf_ack(i_tf_ack), .i_tf_rdata(i_tf_rdata),
    .i_drive_error(i_drive_error), .i_phase_error(i_phase_error),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready),
    .o_block_sectors(o_block_sectors), .o_busy(o_busy), .o_done(o_done),
    .o_failed(o_failed), .o_not_vendor(o_not_vendor));
  atacb_drive_model drv (.i_clk(i_clk), .i_reset(i_reset),
    .i_tf_req(o_tf_req), .i_tf_write(o_tf_write), .i_tf_ctl(o_tf_ctl),
    .i_tf_addr(o_tf_addr), .i_tf_wdata(o_tf_wdata), .i_slow(slow),
    .i_busy_reads(busy_n), .o_tf_ack(i_tf_ack), .o_tf_rdata(i_tf_rdata));

  // free-running clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // collect bytes taken from the fifo
  always @(posedge i_clk) begin
    if (o_rd_valid === 1'b1 && i_rd_ready === 1'b1 && ce === 1'b1) begin
      rx_q.push_back(o_rd_data);
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a spent bound counts as a mismatch and ends the run
  task automatic tmo(input int n, lim);
    if (n >= lim) begin
      bad_count++;
      print_verdict();
    end
  endtask
  // build a block; reserved bytes stay zero
  task automatic mk(input atacb_byte_t act, mask, cnt);
    blk = '{default: 8'h00};
    blk[0] = SIG;
    blk[1] = 8'h24;
    blk[2] = act;
    blk[3] = mask;
    blk[4] = cnt;
    for (int k = 0; k < 8; k++) blk[5+k] = wd[k];
  endtask
  // offer all sixteen bytes, each held until taken
  task automatic send();
    int n;
    for (int i = 0; i < 16; i++) begin
      i_cmd_valid <= 1'b1;
      i_cmd_byte <= blk[i];
      n = 0;
      do begin
        @(posedge i_clk);
        n++;
      end while (o_cmd_ready !== 1'b1 && n < 99);
      tmo(n, 99);
    end
    i_cmd_valid <= 1'b0;
  endtask
  task automatic wait_end();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_done !== 1'b1 && o_not_vendor !== 1'b1 && n < 5000);
    f = o_failed;
    nv = o_not_vendor;
    tmo(n, 5000);
  endtask
  task automatic run();
    send();
    wait_end();
  endtask
  task automatic collect(input int cnt);
    int n;
    n = 0;
    while (rx_q.size() < cnt && n < 500) begin
      @(posedge i_clk);
      n++;
    end
    tmo(n, 500);
  endtask

  // main sequence
  initial begin
    i_reset = 1'b1;
    i_lun_dev = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd_byte = 8'h00;
    i_xfer_len = 16'h0000;
    {i_drive_error, i_phase_error, slow, busy_n} = 7'h00;
    i_rd_ready = 1'b1;
    ce = 1'b1;
    for (int k = 0; k < 8; k++) wd[k] = 8'h61 + k[7:0];
    wd[6] = 8'hE0; // drive bit clear in the block
    repeat (4) @(posedge i_clk);
    chk("sectors at reset", o_block_sectors, 9'h100);
    chk("busy at reset", o_busy, 1'b0);
    i_reset <= 1'b0;
    @(posedge i_clk);
    // block counts: legal ones poll once, illegal ones touch nothing
    foreach (rows[x]) begin
      mk(8'h00, 8'h00, rows[x].cnt);
      l0 = drv.lcount;
      run();
      chk("failed", f, rows[x].fail);
      chk("accesses", 16'(drv.lcount - l0), !rows[x].fail);
      if (!rows[x].fail) begin
        chk("sectors", o_block_sectors, rows[x].sect);
      end
    end
    // read-back of a sparse mask
    i_xfer_len <= 16'h0008;
    mk(8'h05, 8'hA5, 8'h01);
    l0 = drv.lcount;
    k0 = l0;
    run();
    collect(8);
    for (r = 0; r < 8; r++) begin
      e = (r == 0) ? 8'h50 : 8'hA0 + r[7:0];
      chk("readback byte", rx_q[r], blk[3][r] ? e : 8'h00);
      if (blk[3][r]) begin
        chk("readback access", drv.log_a[k0],
          {1'b0, r == 0, (r == 0) ? 3'h6 : r[2:0], e});
        k0++;
      end
    end
    chk("readback count", 16'(drv.lcount - l0), 16'h4);
    // busy polling before the read-back
    busy_n <= 4'h3;
    mk(8'h01, 8'h01, 8'h01);
    l0 = drv.lcount;
    rx_q.delete();
    run();
    collect(1);
    chk("poll count", 16'(drv.lcount - l0), 16'h5);
    chk("first poll", drv.log_a[l0], 13'h0E80);
    chk("last poll", drv.log_a[l0+3], 13'h0E50);
    chk("alt byte", rx_q[0], 8'h50);
    // register writes, early and late drive selection
    i_xfer_len <= 16'h0000;
    for (int t = 0; t < 2; t++) begin
      mk(t ? 8'h26 : 8'h04, 8'hFF, 8'h01);
      l0 = drv.lcount;
      run();
      for (int k = 0; k < 8; k++) begin
        if (t) r = (k == 7) ? 6 : (k == 6) ? 7 : k;
        else r = (k == 0) ? 6 : (k == 7) ? 7 : k - 1;
        e = (r == 6) ? (t ? 8'hE0 : 8'hF0) : wd[r];
        chk("write order", drv.log_a[l0+k],
          {1'b1, r == 0, (r == 0) ? 3'h6 : r[2:0], e});
      end
    end
    // data phase through a full fifo with a slow drive
    i_xfer_len <= 16'h0014;
    slow <= 1'b1;
    i_rd_ready <= 1'b0;
    mk(8'h04, 8'h00, 8'h01);
    d0 = drv.dcount;
    rx_q.delete();
    send();
    repeat (300) @(posedge i_clk);
    chk("stall valid", o_rd_valid, 1'b1);
    chk("stall busy", o_busy, 1'b1);
    chk("stall reads", (drv.dcount - d0) inside {16, 17}, 1'b1);
    // clock enable low freezes the fifo although the sink is ready
    k0 = drv.dcount;
    ce <= 1'b0;
    i_rd_ready <= 1'b1;
    repeat (10) @(posedge i_clk);
    chk("frozen pops", rx_q.size(), 16'h0);
    chk("frozen valid", o_rd_valid, 1'b1);
    chk("frozen reads", 16'(drv.dcount - k0), 16'h0);
    ce <= 1'b1;
    wait_end();
    collect(20);
    chk("data status", f, 1'b0);
    for (int k = 0; k < 20; k++) begin
      chk("data byte", rx_q[k], 8'(d0 + k) ^ 8'h5A);
    end
    // drive and phase errors, halted or ignored
    slow <= 1'b0;
    i_xfer_len <= 16'h0008;
    foreach (errs[x]) begin
      {i_drive_error, i_phase_error} <= errs[x][9:8];
      mk(errs[x][7:0], 8'h00, 8'h01);
      d0 = drv.dcount;
      run();
      chk("halt status", f, errs[x][10]);
      chk("halt reads", 16'(drv.dcount - d0),
        errs[x][10] ? 16'h1 : 16'h8);
      repeat (30) @(posedge i_clk);
      rx_q.delete();
    end
    {i_drive_error, i_phase_error} <= 2'b00;
    // foreign signature, then foreign subcommand
    mk(8'h04, 8'h00, 8'h01);
    blk[0] = ~SIG;
    l0 = drv.lcount;
    run();
    chk("foreign sig", nv, 1'b1);
    blk[0] = SIG;
    blk[1] = 8'h25;
    run();
    chk("foreign sub", nv, 1'b1);
    chk("foreign access", 16'(drv.lcount - l0), 16'h0);
    // reset in mid-transfer, then a block offered straight after release
    i_xfer_len <= 16'h0014;
    mk(8'h04, 8'h00, 8'h01);
    send();
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    chk("reset busy", o_busy, 1'b0);
    chk("reset request", o_tf_req, 1'b0);
    chk("reset fifo", o_rd_valid, 1'b0);
    chk("reset sectors", o_block_sectors, 9'h100);
    blk[0] = ~SIG;
    run();
    chk("after reset", nv, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
